/* File: rtl/cmc_cfg.svh */
// Offsets, field positions, reset values and write masks of the clock multiplier control block.
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH

// Register offsets on the serial control port.
`define CMC_OFF_OUT_BYPASS   8'h00
`define CMC_OFF_IN_PRIORITY  8'h01
`define CMC_OFF_LOOP_BW      8'h02

// Reset values of the three registers.
`define CMC_RST_OUT_BYPASS   8'h14
`define CMC_RST_IN_PRIORITY  8'he4
`define CMC_RST_LOOP_BW      8'h42

// Bits that software may change; every other bit keeps its reset value.
`define CMC_WMASK_OUT_BYPASS  8'h22
`define CMC_WMASK_IN_PRIORITY 8'hff
`define CMC_WMASK_LOOP_BW     8'hf0

// Field positions.
`define CMC_BIT_FORCE_ON     5
`define CMC_BIT_BYPASS       1
`define CMC_BW_MSB           7
`define CMC_BW_LSB           4
`define CMC_RANK_W           2
`define CMC_RANKS            4

`endif

/* File: rtl/cmc_pkg.sv */
// Types shared by the clock multiplier control block.
package cmc_pkg;

    // Register data byte.
    typedef logic [7:0] cmc_byte_t;

    // Input clock selection method; the enum order gives the field codes 00 to 11.
    typedef enum logic [1:0] {
        CMC_SEL_MANUAL,
        CMC_SEL_AUTO_NONREV,
        CMC_SEL_AUTO_REV,
        CMC_SEL_RESERVED
    } cmc_selmode_e;

endpackage : cmc_pkg

/* File: rtl/cmc_sync3.sv */
// Three-stage synchroniser that passes a change once its last two stages agree.
`timescale 1ns/100ps
`default_nettype none

module cmc_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] sync_d;

    // Each bit updates only where the second and third stages agree.
    always_comb begin
        sync_d = sync_o;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2_q[i] == stage3_q[i]) begin
                sync_d[i] = stage3_q[i];
            end
        end
    end

    // The first stage is read by the second stage alone.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q   <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
            sync_o   <= '0;
        end else begin
            meta_q   <= async_i;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
            sync_o   <= sync_d;
        end
    end

endmodule : cmc_sync3

`default_nettype wire

/* File: rtl/cmc_ctrl_regs.sv */
// Output, bypass, input priority and loop bandwidth control registers of the clock multiplier.
`include "cmc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module cmc_ctrl_regs
    import cmc_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic [1:0] selection_mode_i,
    input  wire logic       squelch_during_cal_i,
    input  wire logic       cmos_format_i,
    input  wire logic [1:0] active_input_i,
    input  wire logic       cal_start_i,
    input  wire logic       cal_busy_i,
    input  wire logic       cal_done_i,
    output logic [7:0]      reg_rdata_o,
    output logic            reg_rvalid_o,
    output logic            output_clock_en_o,
    output logic            cmos_drive_en_o,
    output logic            bypass_en_o,
    output logic [1:0]      bypass_source_o,
    output logic [3:0]      loop_bw_code_o,
    output logic            loop_bw_pending_o,
    output logic            auto_select_o,
    output logic            revertive_o,
    output logic [1:0]      first_rank_input_o,
    output logic [1:0]      second_rank_input_o,
    output logic [1:0]      third_rank_input_o,
    output logic [1:0]      fourth_rank_input_o,
    output logic [15:0]     rank_onehot_o
);

    cmc_byte_t     out_bypass_q;
    cmc_byte_t     out_bypass_d;
    cmc_byte_t     in_priority_q;
    cmc_byte_t     in_priority_d;
    cmc_byte_t     loop_bw_q;
    cmc_byte_t     loop_bw_d;
    logic [1:0]    cal_sync;
    logic          cal_busy_s;
    logic          cal_done_s;
    logic [3:0]    bw_active_d;
    cmc_byte_t     rdata_d;
    logic          clk_en_d;
    logic          cmos_en_d;
    logic          auto_d;
    logic          revert_d;
    logic [15:0]   onehot_d;
    cmc_selmode_e  mode;

    // Calibration status comes from the analogue loop and is resynchronised here.
    cmc_sync3 #(
        .WIDTH (2)
    ) u_cal_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .async_i ({cal_done_i, cal_busy_i}),
        .sync_o  (cal_sync)
    );

    assign cal_busy_s = cal_sync[0];
    assign cal_done_s = cal_sync[1];
    assign mode       = cmc_selmode_e'(selection_mode_i);

    // Register writes merge writable bits with the fixed reset pattern of read-only bits.
    always_comb begin
        out_bypass_d  = out_bypass_q;
        in_priority_d = in_priority_q;
        loop_bw_d     = loop_bw_q;
        if (reg_wr_i) begin
            if (reg_addr_i == `CMC_OFF_OUT_BYPASS) begin
                out_bypass_d = (reg_wdata_i & `CMC_WMASK_OUT_BYPASS)
                             | (`CMC_RST_OUT_BYPASS & ~`CMC_WMASK_OUT_BYPASS);
            end else if (reg_addr_i == `CMC_OFF_IN_PRIORITY) begin
                in_priority_d = reg_wdata_i & `CMC_WMASK_IN_PRIORITY;
            end else if (reg_addr_i == `CMC_OFF_LOOP_BW) begin
                loop_bw_d = (reg_wdata_i & `CMC_WMASK_LOOP_BW)
                          | (`CMC_RST_LOOP_BW & ~`CMC_WMASK_LOOP_BW);
            end
        end
    end

    // Register storage with its documented reset pattern.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_bypass_q  <= `CMC_RST_OUT_BYPASS;
            in_priority_q <= `CMC_RST_IN_PRIORITY;
            loop_bw_q     <= `CMC_RST_LOOP_BW;
        end else begin
            out_bypass_q  <= out_bypass_d;
            in_priority_q <= in_priority_d;
            loop_bw_q     <= loop_bw_d;
        end
    end

    // The loop only sees a new bandwidth code when a calibration is started.
    always_comb begin
        bw_active_d = loop_bw_code_o;
        if (cal_start_i) begin
            bw_active_d = loop_bw_d[`CMC_BW_MSB:`CMC_BW_LSB];
        end
    end

    // Active bandwidth code and its pending flag.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loop_bw_code_o    <= 4'h4;
            loop_bw_pending_o <= 1'b0;
        end else begin
            loop_bw_code_o    <= bw_active_d;
            loop_bw_pending_o <= (loop_bw_d[`CMC_BW_MSB:`CMC_BW_LSB] != bw_active_d);
        end
    end

    // Output enable: force-on wins, else wait for calibration and honour squelch while busy.
    always_comb begin
        if (out_bypass_d[`CMC_BIT_FORCE_ON]) begin
            clk_en_d = 1'b1;
        end else begin
            clk_en_d = cal_done_s && !(cal_busy_s && squelch_during_cal_i);
        end
        cmos_en_d = clk_en_d && cmos_format_i && !out_bypass_d[`CMC_BIT_BYPASS];
    end

    // Ranks decode to one-hot input masks in every selection mode, manual ones included.
    always_comb begin
        onehot_d = '0;
        for (int r = 0; r < `CMC_RANKS; r++) begin
            onehot_d[r*4 + int'(in_priority_d[r*`CMC_RANK_W +: `CMC_RANK_W])] = 1'b1;
        end
        auto_d   = (mode == CMC_SEL_AUTO_NONREV) || (mode == CMC_SEL_AUTO_REV);
        revert_d = (mode == CMC_SEL_AUTO_REV);
    end

    // Control outputs registered from the next register values and the calibration status, selection mode, format and active input.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_clock_en_o   <= 1'b0;
            cmos_drive_en_o     <= 1'b0;
            bypass_en_o         <= 1'b0;
            bypass_source_o     <= 2'h0;
            auto_select_o       <= 1'b0;
            revertive_o         <= 1'b0;
            first_rank_input_o  <= 2'h0;
            second_rank_input_o <= 2'h1;
            third_rank_input_o  <= 2'h2;
            fourth_rank_input_o <= 2'h3;
            rank_onehot_o       <= 16'h8421;
        end else begin
            output_clock_en_o   <= clk_en_d;
            cmos_drive_en_o     <= cmos_en_d;
            bypass_en_o         <= out_bypass_d[`CMC_BIT_BYPASS];
            bypass_source_o     <= active_input_i;
            auto_select_o       <= auto_d;
            revertive_o         <= revert_d;
            first_rank_input_o  <= in_priority_d[1:0];
            second_rank_input_o <= in_priority_d[3:2];
            third_rank_input_o  <= in_priority_d[5:4];
            fourth_rank_input_o <= in_priority_d[7:6];
            rank_onehot_o       <= onehot_d;
        end
    end

    // Read data; unmapped offsets read as zero.
    always_comb begin
        rdata_d = reg_rdata_o;
        if (reg_rd_i) begin
            if (reg_addr_i == `CMC_OFF_OUT_BYPASS) begin
                rdata_d = out_bypass_q;
            end else if (reg_addr_i == `CMC_OFF_IN_PRIORITY) begin
                rdata_d = in_priority_q;
            end else if (reg_addr_i == `CMC_OFF_LOOP_BW) begin
                rdata_d = loop_bw_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // Read data holds until the next read; valid pulses one cycle.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rdata_o  <= rdata_d;
            reg_rvalid_o <= reg_rd_i;
        end
    end

endmodule : cmc_ctrl_regs

`default_nettype wire

/* File: sim/cmc_ctrl_regs_monitor.sv */
// Port-level checks of the clock multiplier control registers.
`timescale 1ns/100ps
`default_nettype none

module cmc_ctrl_regs_monitor (
    input wire logic        mclk_i, rst_n_i, reg_wr_i, cal_start_i, cal_done_i, reg_rvalid_o,
    input wire logic        output_clock_en_o, cmos_drive_en_o, bypass_en_o, loop_bw_pending_o,
    input wire logic        auto_select_o, revertive_o,
    input wire logic [1:0]  selection_mode_i, first_rank_input_o, second_rank_input_o,
    input wire logic [1:0]  third_rank_input_o, fourth_rank_input_o,
    input wire logic [3:0]  loop_bw_code_o,
    input wire logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o,
    input wire logic [15:0] rank_onehot_o
);
    // All checks run on the one clock and pause during reset.
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_force_on_drive: assert property (reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[5]
        |=> output_clock_en_o) else $error("force-on write left outputs off");
    a_squelch_until_cal: assert property ((!cal_done_i)[*8] ##0 (reg_wr_i &&
        reg_addr_i == 8'h00 && !reg_wdata_i[5]) |=> !output_clock_en_o)
        else $error("outputs on before calibration done");
    a_bypass_follows: assert property (reg_wr_i && reg_addr_i == 8'h00
        |=> bypass_en_o == $past(reg_wdata_i[1])) else $error("bypass bit not followed");
    a_cmos_no_bypass: assert property (bypass_en_o |-> !cmos_drive_en_o)
        else $error("CMOS drive during bypass");
    a_rank_fields: assert property (reg_wr_i && reg_addr_i == 8'h01 |=> {fourth_rank_input_o,
        third_rank_input_o, second_rank_input_o, first_rank_input_o} == $past(reg_wdata_i))
        else $error("rank fields wrong");
    a_rank_decode: assert property (rank_onehot_o == {4'h1 << fourth_rank_input_o,
        4'h1 << third_rank_input_o, 4'h1 << second_rank_input_o, 4'h1 << first_rank_input_o})
        else $error("rank one-hot wrong");
    a_bw_write_hold: assert property (reg_wr_i && reg_addr_i == 8'h02 && !cal_start_i
        |=> $stable(loop_bw_code_o)) else $error("bandwidth changed without calibration");
    a_bw_cal_apply: assert property (cal_start_i |=> !loop_bw_pending_o)
        else $error("bandwidth still pending after calibration start");
    a_ro_bits_kept: assert property (reg_rvalid_o && $past(reg_addr_i) == 8'h00
        |-> (reg_rdata_o & 8'hdd) == 8'h14) else $error("read-only bits changed");
    a_auto_mode: assert property (selection_mode_i == 2'b10 |=> auto_select_o && revertive_o)
        else $error("revertive mode not flagged");
endmodule : cmc_ctrl_regs_monitor

bind cmc_ctrl_regs cmc_ctrl_regs_monitor cmc_ctrl_regs_monitor_i (.*);
`default_nettype wire

/* File: sim/tb_cmc_ctrl_regs.sv */
// Self-checking testbench for the clock multiplier control registers.
`timescale 1ns/100ps
`default_nettype none

module tb_cmc_ctrl_regs
    import cmc_pkg::*;
;
    logic        mclk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, cal_start_i = 0;
    logic        cal_busy_i = 0, cal_done_i = 0, squelch_during_cal_i = 0, cmos_format_i = 0;
    logic [1:0]  selection_mode_i = 0, active_input_i = 0;
    cmc_byte_t   reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, v;
    logic        reg_rvalid_o, output_clock_en_o, cmos_drive_en_o, bypass_en_o;
    logic        loop_bw_pending_o, auto_select_o, revertive_o;
    logic [1:0]  bypass_source_o, first_rank_input_o, second_rank_input_o;
    logic [1:0]  third_rank_input_o, fourth_rank_input_o;
    logic [3:0]  loop_bw_code_o;
    logic [1:0]  src_exp = 0;
    logic        fmt_exp = 0;
    logic [15:0] rank_onehot_o;
    int          n_errors = 0, n_compared = 0, i;
    integer      seed = 57833;
    cmc_byte_t   exp_q[$];

    cmc_ctrl_regs cmc_ctrl_regs_i (.*);

    // Free-running clock, 50 ns period.
    initial forever #25 mclk_i = ~mclk_i;

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task end_of_test;
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task wr(input cmc_byte_t a, input cmc_byte_t d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task rd(input cmc_byte_t a, input cmc_byte_t e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
    endtask : rd

    task settle(input int n);
        repeat (n) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask : settle

    // Random active input and output format on every clock.
    always @(posedge mclk_i) begin
        active_input_i <= 2'($random(seed));
        cmos_format_i <= 1'($random(seed));
        src_exp <= active_input_i;
        fmt_exp <= cmos_format_i;
    end

    // Each returned read byte is matched against the oldest queued expectation.
    always @(posedge mclk_i) begin
        if (reg_rvalid_o === 1'b1) check(reg_rdata_o, exp_q.pop_front());
    end

    // Bound on the whole run.
    initial begin
        repeat (3000) @(posedge mclk_i);
        n_errors++;
        $display("ERROR %0t: run did not finish", $time);
        end_of_test();
    end

    // Main sequence: reset values, writes, bandwidth, calibration and modes.
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(8'h00, 8'h14);
        rd(8'h01, 8'he4);
        rd(8'h02, 8'h42);
        rd(8'h03, 8'h00);
        settle(0);
        check(rank_onehot_o, 16'h8421);
        check(output_clock_en_o, 1'b0);
        // Force-on with bypass before the first calibration: outputs on, CMOS drive off.
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h36);
        check(output_clock_en_o, 1'b1);
        check(bypass_en_o, 1'b1);
        check(cmos_drive_en_o, 1'b0);
        wr(8'h00, 8'h00);
        settle(0);
        check(output_clock_en_o, 1'b0);
        check(bypass_en_o, 1'b0);
        repeat (4) begin
            v = 8'($random(seed));
            wr(8'h01, v);
            rd(8'h01, v);
            settle(0);
            check({fourth_rank_input_o, third_rank_input_o, second_rank_input_o,
                   first_rank_input_o}, v);
            for (i = 0; i < 4; i++) check(rank_onehot_o[4*i+:4], 4'h1 << v[2*i+:2]);
        end
        wr(8'h02, 8'hff);
        rd(8'h02, 8'hf2);
        settle(0);
        check({loop_bw_pending_o, loop_bw_code_o}, 5'h14);
        @(posedge mclk_i);
        cal_start_i <= 1'b1;
        @(posedge mclk_i);
        cal_start_i <= 1'b0;
        settle(0);
        check({loop_bw_pending_o, loop_bw_code_o}, 5'h0f);
        @(posedge mclk_i);
        cal_done_i <= 1'b1;
        settle(8);
        check(output_clock_en_o, 1'b1);
        check(cmos_drive_en_o, fmt_exp);
        check(bypass_source_o, src_exp);
        @(posedge mclk_i);
        squelch_during_cal_i <= 1'b1;
        cal_busy_i <= 1'b1;
        settle(8);
        check(output_clock_en_o, 1'b0);
        wr(8'h00, 8'h20);
        settle(0);
        check(output_clock_en_o, 1'b1);
        wr(8'h00, 8'h00);
        squelch_during_cal_i <= 1'b0;
        settle(8);
        check(output_clock_en_o, 1'b1);
        for (i = 0; i < 4; i++) begin
            @(posedge mclk_i);
            selection_mode_i <= 2'(i);
            settle(1);
            check({auto_select_o, revertive_o}, {i == 1 || i == 2, i == 2});
        end
        settle(2);
        check(16'(exp_q.size()), 16'h0000);
        end_of_test();
    end
endmodule : tb_cmc_ctrl_regs
`default_nettype wire
